/* icm_pkg.sv */
/*
 * Shared constants and types of the two-wire host port.
 * Assumes a 40 MHz system clock and an 8-bit register port.
 */
package icm_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [3:0] ADDR_STATUS   = 4'h0;
    localparam logic [3:0] ADDR_CTRL_ONE = 4'h1;
    localparam logic [3:0] ADDR_SEQ_CTRL = 4'h2;
    localparam logic [3:0] ADDR_CTRL_TRI = 4'h3;
    localparam logic [3:0] ADDR_MASK     = 4'h4;
    localparam logic [3:0] ADDR_RELOAD   = 4'h5;
    localparam logic [3:0] ADDR_BUFFER   = 4'h6;
    localparam logic [3:0] ADDR_IRQ_FLAG = 4'h7;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
    // ==========================================================
    // Field positions
    localparam int CTRL_WRITE_COLLISION_FLAG  = 7;
    localparam int CTRL_OVF   = 6;
    localparam int CTRL_EN    = 5;
    localparam int SEQ_START  = 0;
    localparam int SEQ_RSTART = 1;
    localparam int SEQ_STOP   = 2;
    localparam int SEQ_RECV   = 3;
    localparam int SEQ_ACK    = 4;
    localparam int SEQ_ACKDT  = 5;
    localparam int SEQ_ACKST  = 6;
    localparam int SEQ_LOCK_W = 5;
    localparam int IRQ_DONE   = 0;
    localparam int IRQ_WRITE_COLLISION_FLAG   = 1;
    localparam int IRQ_W      = 2;
    // ==========================================================
    // Reset values and codes
    localparam logic [7:0] RESET_BYTE  = 8'h00;
    localparam logic [3:0] MODE_MASTER = 4'h8;
    localparam logic [3:0] BITS_TX     = 4'h9;
    localparam logic [3:0] BITS_RX     = 4'h8;
    localparam logic [3:0] BITS_ACK    = 4'h1;
    // ==========================================================
    // Sequencer
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_START  = 3'b001,
        ST_RSTART = 3'b010,
        ST_STOP   = 3'b011,
        ST_BITS   = 3'b100
    } icm_state_type;
    typedef enum logic [1:0] {
        BM_TX  = 2'b00,
        BM_RX  = 2'b01,
        BM_ACK = 2'b10
    } icm_bit_mode_type;
endpackage

/* icm_sync.sv */
/*
 * Two-stage synchroniser, one lane per bit.
 * Assumes asynchronous inputs and a reset already synchronised.
 */
`timescale 1ns/1ps
module icm_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clock,  // System clock
    input  wire logic             rst_n,  // Synchronised reset
    input  wire logic [WIDTH-1:0] async,  // Raw pin levels
    output logic      [WIDTH-1:0] synced  // Stable levels
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } icm_sync_type;

    icm_sync_type r;
    icm_sync_type next_r;

    // ==========================================================
    // Per-bit stages
    for (genvar i = 0; i < WIDTH; i++) begin : g_lane
        always_comb begin
            next_r.meta[i]   = async[i];
            next_r.stable[i] = r.meta[i];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r <= '1;
        end else begin
            r <= next_r;
        end
    end

    assign synced = r.stable;
endmodule // icm_sync

/* icm_brg.sv */
/*
 * Baud-rate counter: counts down from the reload value and
 * pulses on rollover; held at the reload value while suspended.
 * Assumes the caller suspends it while idle and while its released clock line is held low.
 */
`timescale 1ns/1ps
module icm_brg (
    input  wire logic       clock,   // System clock
    input  wire logic       rst_n,   // Synchronised reset
    input  wire logic       suspend, // Hold and reload
    input  wire logic [7:0] reload,  // Reload value
    output logic            tick     // Rollover pulse
);
    typedef struct packed {
        logic [7:0] count;
    } icm_brg_type;

    icm_brg_type r;
    icm_brg_type next_r;

    // ==========================================================
    // Counter
    always_comb begin
        next_r = r;
        if (suspend || r.count == 8'h00) begin
            next_r.count = reload;
        end else begin
            next_r.count = r.count - 8'h01;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tick = !suspend && r.count == 8'h00;
endmodule // icm_brg

/* icm_master.sv */
/*
 * Two-wire host port: register set, start/restart/stop and
 * byte sequencer with clock arbitration, write collision and
 * sequence-control locking while a start is sent, plus a maskable interrupt.
 * Assumes open-drain pads outside and a 40 MHz system clock.
 */
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module icm_master
    import icm_pkg::*;
(
    input  wire logic       clock,   // System clock, 40 MHz
    input  wire logic       arst_n,  // Asynchronous reset
    input  wire logic [3:0] addr,    // Register address
    input  wire logic [7:0] wdata,   // Write data
    input  wire logic       wr,      // Write strobe
    input  wire logic       rd,      // Read strobe
    output logic      [7:0] rdata,   // Read data, next cycle
    output logic            irq,     // Interrupt level
    input  wire logic       scl_in,  // Clock line level
    output logic            scl_out, // Clock line drive value
    output logic            scl_oe,  // Clock line pulled low
    input  wire logic       sda_in,  // Data line level
    output logic            sda_out, // Data line drive value
    output logic            sda_oe   // Data line pulled low
);
    typedef struct packed {
        icm_state_type    state;
        logic [1:0]       phase;
        logic [3:0]       bit_cnt;
        icm_bit_mode_type mode;
        logic [7:0]       shift;
        logic             scl_low;
        logic             sda_low;
        logic [1:0]       stat_ctl;
        logic             full;
        logic             seen_start;
        logic             seen_stop;
        logic [7:0]       ctrl_one;
        logic [7:0]       seq_ctrl;
        logic [7:0]       ctrl_tri;
        logic [7:0]       mask;
        logic [7:0]       reload;
        logic [7:0]       buffer;
        logic [IRQ_W-1:0] irq_flag;
        logic [IRQ_W-1:0] irq_mask;
        logic [7:0]       rdata;
    } icm_regs_type;

    icm_regs_type r;
    icm_regs_type next_r;
    logic [1:0]   rst_pipe;
    logic         rst_n;
    logic [1:0]   lines;
    logic         scl_s;
    logic         sda_s;
    logic         tick;
    logic         suspend;
    logic         busy;
    logic         master;

    // ==========================================================
    // Reset release
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // ==========================================================
    // Line sampling and baud-rate counter
    icm_sync #(
        .WIDTH (2)
    ) u_sync (
        .clock  (clock),
        .rst_n  (rst_n),
        .async  ({sda_in, scl_in}),
        .synced (lines)
    );
    assign scl_s = lines[0];
    assign sda_s = lines[1];

    assign busy   = r.state != ST_IDLE;
    assign master = r.ctrl_one[CTRL_EN] && r.ctrl_one[3:0] == MODE_MASTER;
    // Released clock held low by another party holds the counter at its reload value
    assign suspend = !busy || (!r.scl_low && !scl_s);

    icm_brg u_brg (
        .clock   (clock),
        .rst_n   (rst_n),
        .suspend (suspend),
        .reload  (r.reload),
        .tick    (tick)
    );

    // ==========================================================
    // Next state
    always_comb begin
        next_r = r;

        // Sequencer
        case (r.state)
            ST_IDLE: begin
                next_r.phase = 2'b00;
                if (master && r.seq_ctrl[SEQ_START]) begin
                    next_r.state   = ST_START;
                    next_r.scl_low = 1'b0;
                    next_r.sda_low = 1'b0;
                end else if (master && r.seq_ctrl[SEQ_RSTART]) begin
                    next_r.state = ST_RSTART;
                end else if (master && r.seq_ctrl[SEQ_STOP]) begin
                    next_r.state = ST_STOP;
                end else if (master && r.seq_ctrl[SEQ_RECV]) begin
                    next_r.state   = ST_BITS;
                    next_r.mode    = BM_RX;
                    next_r.bit_cnt = BITS_RX;
                end else if (master && r.seq_ctrl[SEQ_ACK]) begin
                    next_r.state   = ST_BITS;
                    next_r.mode    = BM_ACK;
                    next_r.bit_cnt = BITS_ACK;
                end
            end
            ST_START: begin
                if (tick && r.phase == 2'b00) begin
                    next_r.sda_low = 1'b1;
                    next_r.phase   = 2'b01;
                end else if (tick) begin
                    next_r.scl_low              = 1'b1;
                    next_r.state                = ST_IDLE;
                    next_r.seq_ctrl[SEQ_START]  = 1'b0;
                    next_r.seen_start           = 1'b1;
                    next_r.seen_stop            = 1'b0;
                    next_r.irq_flag[IRQ_DONE]   = 1'b1;
                end
            end
            ST_RSTART: begin
                if (r.phase == 2'b00) begin
                    next_r.sda_low = 1'b0;
                end
                if (tick) begin
                    next_r.phase = r.phase + 2'b01;
                    case (r.phase)
                        2'b00: begin
                            next_r.scl_low = 1'b0;
                        end
                        2'b01: begin
                            next_r.sda_low = 1'b1;
                        end
                        default: begin
                            next_r.scl_low              = 1'b1;
                            next_r.state                = ST_IDLE;
                            next_r.seq_ctrl[SEQ_RSTART] = 1'b0;
                            next_r.seen_start           = 1'b1;
                            next_r.irq_flag[IRQ_DONE]   = 1'b1;
                        end
                    endcase
                end
            end
            ST_STOP: begin
                if (r.phase == 2'b00) begin
                    next_r.sda_low = 1'b1;
                end
                if (tick) begin
                    next_r.phase = r.phase + 2'b01;
                    case (r.phase)
                        2'b00: begin
                            next_r.scl_low = 1'b0;
                        end
                        2'b01: begin
                            next_r.sda_low = 1'b0;
                        end
                        default: begin
                            next_r.state              = ST_IDLE;
                            next_r.seq_ctrl[SEQ_STOP] = 1'b0;
                            next_r.seen_stop          = 1'b1;
                            next_r.seen_start         = 1'b0;
                            next_r.irq_flag[IRQ_DONE] = 1'b1;
                        end
                    endcase
                end
            end
            ST_BITS: begin
                if (r.phase == 2'b00) begin
                    // Data set up while the clock is held low
                    if (r.mode == BM_TX) begin
                        next_r.sda_low = r.bit_cnt != 4'h1
                                         && !r.shift[7];
                    end else if (r.mode == BM_ACK) begin
                        next_r.sda_low = !r.seq_ctrl[SEQ_ACKDT];
                    end else begin
                        next_r.sda_low = 1'b0;
                    end
                    if (tick) begin
                        next_r.scl_low = 1'b0;
                        next_r.phase   = 2'b01;
                    end
                end else if (tick) begin
                    // Clock high time already covered a full rollover
                    next_r.scl_low = 1'b1;
                    next_r.phase   = 2'b00;
                    next_r.shift   = {r.shift[6:0], sda_s};
                    next_r.bit_cnt = r.bit_cnt - 4'h1;
                    if (r.bit_cnt == 4'h1) begin
                        next_r.state              = ST_IDLE;
                        next_r.sda_low            = 1'b0;
                        next_r.irq_flag[IRQ_DONE] = 1'b1;
                        case (r.mode)
                            BM_TX: begin
                                next_r.full               = 1'b0;
                                next_r.seq_ctrl[SEQ_ACKST] = sda_s;
                            end
                            BM_RX: begin
                                next_r.buffer = {r.shift[6:0], sda_s};
                                next_r.seq_ctrl[SEQ_RECV] = 1'b0;
                                if (r.full) begin
                                    next_r.ctrl_one[CTRL_OVF] = 1'b1;
                                end
                                next_r.full = 1'b1;
                            end
                            default: begin
                                next_r.seq_ctrl[SEQ_ACK] = 1'b0;
                            end
                        endcase
                    end
                end
            end
            default: begin
                next_r.state = ST_IDLE;
            end
        endcase

        // Register writes
        if (wr) begin
            if (addr == ADDR_STATUS) begin
                next_r.stat_ctl = wdata[7:6];
            end else if (addr == ADDR_CTRL_ONE) begin
                next_r.ctrl_one = wdata;
            end else if (addr == ADDR_SEQ_CTRL) begin
                next_r.seq_ctrl[7] = wdata[7];
                next_r.seq_ctrl[SEQ_ACKDT] = wdata[SEQ_ACKDT];
                if (r.state != ST_START) begin
                    next_r.seq_ctrl[SEQ_LOCK_W-1:0] =
                        wdata[SEQ_LOCK_W-1:0];
                end
            end else if (addr == ADDR_CTRL_TRI) begin
                next_r.ctrl_tri = wdata;
            end else if (addr == ADDR_MASK) begin
                next_r.mask = wdata;
            end else if (addr == ADDR_RELOAD) begin
                next_r.reload = wdata;
            end else if (addr == ADDR_BUFFER) begin
                if (busy) begin
                    // Dropped write: buffer left as it was
                    next_r.irq_flag[IRQ_WRITE_COLLISION_FLAG] = 1'b1;
                end else begin
                    next_r.buffer = wdata;
                    next_r.full   = 1'b1;
                    if (master) begin
                        next_r.state   = ST_BITS;
                        next_r.mode    = BM_TX;
                        next_r.bit_cnt = BITS_TX;
                        next_r.shift   = wdata;
                        next_r.phase   = 2'b00;
                    end
                end
            end else if (addr == ADDR_IRQ_FLAG) begin
                next_r.irq_flag = r.irq_flag & ~wdata[IRQ_W-1:0];
            end else if (addr == ADDR_IRQ_MASK) begin
                next_r.irq_mask = wdata[IRQ_W-1:0];
            end
        end

        // Hardware sets win over software clears
        if (wr && addr == ADDR_BUFFER && busy) begin
            next_r.ctrl_one[CTRL_WRITE_COLLISION_FLAG] = 1'b1;
        end
        if (r.state == ST_BITS && r.mode == BM_RX && r.full
            && next_r.state == ST_IDLE) begin
            next_r.ctrl_one[CTRL_OVF] = 1'b1;
        end
        if (r.state != ST_IDLE && next_r.state == ST_IDLE) begin
            next_r.irq_flag[IRQ_DONE] = 1'b1;
        end

        // Register reads
        next_r.rdata = RESET_BYTE;
        if (rd) begin
            if (addr == ADDR_STATUS) begin
                next_r.rdata = {r.stat_ctl, 1'b0, r.seen_stop,
                                r.seen_start, r.state == ST_BITS
                                && r.mode == BM_TX, 1'b0, r.full};
            end else if (addr == ADDR_CTRL_ONE) begin
                next_r.rdata = r.ctrl_one;
            end else if (addr == ADDR_SEQ_CTRL) begin
                next_r.rdata = r.seq_ctrl;
            end else if (addr == ADDR_CTRL_TRI) begin
                next_r.rdata = r.ctrl_tri;
            end else if (addr == ADDR_MASK) begin
                next_r.rdata = r.mask;
            end else if (addr == ADDR_RELOAD) begin
                next_r.rdata = r.reload;
            end else if (addr == ADDR_BUFFER) begin
                next_r.rdata = r.buffer;
                if (!busy) begin
                    next_r.full = 1'b0;
                end
            end else if (addr == ADDR_IRQ_FLAG) begin
                next_r.rdata = {6'h00, r.irq_flag};
            end else if (addr == ADDR_IRQ_MASK) begin
                next_r.rdata = {6'h00, r.irq_mask};
            end
        end

        // Port switched off drops the lines and the sequence
        if (!r.ctrl_one[CTRL_EN]) begin
            next_r.state   = ST_IDLE;
            next_r.scl_low = 1'b0;
            next_r.sda_low = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ==========================================================
    // Outputs
    assign rdata   = r.rdata;
    assign irq     = |(r.irq_flag & r.irq_mask);
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe  = r.scl_low;
    assign sda_oe  = r.sda_low;
endmodule // icm_master

/* icm_monitor.sv */
/*
 * Checker of the two-wire host port, bound to its top module.
 * Assumes it sees the top ports only; the reload value is
 * shadowed from register writes.
 */
`timescale 1ns/1ps
module icm_monitor
    import icm_pkg::*;
(
    input wire logic       clock,  // System clock
    input wire logic       arst_n, // Asynchronous reset
    input wire logic [3:0] addr,   // Register address
    input wire logic [7:0] wdata,  // Write data
    input wire logic       wr,     // Write strobe
    input wire logic       rd,     // Read strobe
    input wire logic [7:0] rdata,  // Read data
    input wire logic       scl_in, // Clock line level
    input wire logic       scl_oe  // Clock line pulled low
);
    logic [7:0] rl;
    logic [9:0] hi_cnt;
    logic       rd_one;
    logic       write_collision_flag_seen;
    logic       pulled;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    // ==========================================================
    // Shadow state
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rl        <= 8'h00;
            hi_cnt    <= 10'h000;
            rd_one    <= 1'b0;
            write_collision_flag_seen <= 1'b0;
            pulled    <= 1'b0;
        end else begin
            // High phase after idle has no bound; time only after a pull
            if (wr && addr == ADDR_SEQ_CTRL && wdata[SEQ_START]) begin
                pulled <= 1'b0;
            end else if (scl_oe) begin
                pulled <= 1'b1;
            end
            if (wr && addr == ADDR_RELOAD) begin
                rl <= wdata;
            end
            if (scl_in && !scl_oe) begin
                hi_cnt <= (hi_cnt == 10'h3FF) ? hi_cnt : hi_cnt + 10'h001;
            end else begin
                hi_cnt <= 10'h000;
            end
            rd_one <= rd && addr == ADDR_CTRL_ONE;
            if (wr && addr == ADDR_CTRL_ONE && !wdata[7]) begin
                write_collision_flag_seen <= 1'b0;
            end else if (rd_one && rdata[7]) begin
                write_collision_flag_seen <= 1'b1;
            end
        end
    end
    // ==========================================================
    // Assertions
    held_low_a: assert property (!scl_oe && !scl_in |=> !scl_oe)
        else $error("clock pulled while released line still low");
    reload_span_a: assert property ($rose(scl_oe) && pulled |->
        int'(hi_cnt) <= 3 * int'(rl) + 9)
        else $error("clock high phase longer than reload count");
    min_high_a: assert property ($rose(scl_oe) |->
        hi_cnt >= {2'b00, rl} + 10'h001)
        else $error("clock high phase shorter than one rollover");
    write_collision_flag_sticky_a: assert property (rd && addr == ADDR_CTRL_ONE
        && write_collision_flag_seen |=> rdata[7])
        else $error("collision flag lost without a clearing write");
    rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
        else $error("read data present without a read");
    unmapped_read_a: assert property (rd && addr > ADDR_IRQ_MASK
        |=> rdata == 8'h00)
        else $error("unmapped address returned data");
    cover property ($rose(scl_oe));
    cover property (!scl_oe && !scl_in);
    cover property (rd && addr == ADDR_CTRL_ONE && write_collision_flag_seen);
endmodule // icm_monitor

/* icm_bus_slave.sv */
/*
 * Far-side model: a slave that stretches the clock line after
 * each falling edge and acknowledges every byte.
 * Assumes open-drain lines whose levels the bench resolves.
 */
`timescale 1ns/1ps
module icm_bus_slave (
    input  wire logic       clock,       // System clock
    input  wire logic       arst_n,      // Reset
    input  wire logic       scl,         // Clock line level
    input  wire logic       sda,         // Data line level
    input  wire logic [7:0] hold_cycles, // Stretch length
    output logic            scl_hold,    // Pull clock line low
    output logic            sda_hold,    // Pull data line low
    output logic      [7:0] rx_byte      // Last byte received
);
    logic       scl_q;
    logic       sda_q;
    logic [7:0] cnt;
    logic [7:0] sh;
    logic [3:0] bits;
    assign scl_hold = (cnt != 8'h00);
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
            cnt      <= 8'h00;
            sh       <= 8'h00;
            bits     <= 4'h0;
            sda_hold <= 1'b0;
            rx_byte  <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end
            if (scl && scl_q && sda_q && !sda) begin
                bits <= 4'h0;
            end else if (scl && !scl_q) begin
                sh   <= {sh[6:0], sda};
                bits <= bits + 4'h1;
                if (bits == 4'h8) begin
                    rx_byte <= sh;
                end
            end else if (!scl && scl_q) begin
                // Stretch, and drive the acknowledge in the ninth bit
                cnt      <= hold_cycles;
                sda_hold <= (bits == 4'h8);
                if (bits == 4'h9) begin
                    bits <= 4'h0;
                end
            end
        end
    end
endmodule // icm_bus_slave

/* testbench.sv */
/*
 * Self-checking bench of the two-wire host port.
 * Assumes open-drain lines with pull-ups and a stretching slave.
 */
`timescale 1ns/1ps
module testbench;
    import icm_pkg::*;
    logic       clock;
    logic       arst_n;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       irq;
    logic       scl_in;
    logic       scl_oe;
    logic       sda_in;
    logic       sda_oe;
    logic       scl_drv;
    logic       sda_drv;
    logic       scl_hold;
    logic       sda_hold;
    logic [7:0] hold;
    logic [7:0] rx_byte;
    int         n_errors;
    int         total_checks;
    assign scl_in = !scl_oe && !scl_hold;
    assign sda_in = !sda_oe && !sda_hold;
    icm_master u_icm_master (.clock(clock), .arst_n(arst_n),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .irq(irq), .scl_in(scl_in), .scl_out(scl_drv), .scl_oe(scl_oe),
        .sda_in(sda_in), .sda_out(sda_drv), .sda_oe(sda_oe));
    icm_bus_slave u_icm_bus_slave (.clock(clock), .arst_n(arst_n),
        .scl(scl_in), .sda(sda_in), .hold_cycles(hold),
        .scl_hold(scl_hold), .sda_hold(sda_hold), .rx_byte(rx_byte));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // ==========================================================
    // Tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] m,
                          input logic [7:0] e);
        logic [7:0] d;
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge clock);
        chk(d & m, e);
    endtask
    task automatic wait_done;
        int i;
        i = 0;
        while (irq !== 1'b1 && i < 4000) begin
            @(posedge clock);
            i++;
        end
        chk({7'h00, irq}, 8'h01);
        wr_reg(ADDR_IRQ_FLAG, 8'h01);
        chk({7'h00, irq}, 8'h00);
    endtask
    task automatic wrap_up;
        $display("Checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial begin
        arst_n = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        hold = 8'h00;
        n_errors = 0;
        total_checks = 0;
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd_chk(ADDR_CTRL_ONE, 8'hFF, 8'h00);
        rd_chk(4'hF, 8'hFF, 8'h00);
        wr_reg(ADDR_RELOAD, 8'hFF);
        rd_chk(ADDR_RELOAD, 8'hFF, 8'hFF);
        wr_reg(ADDR_RELOAD, 8'h03);
        wr_reg(ADDR_IRQ_MASK, 8'h01);
        wr_reg(ADDR_CTRL_ONE, 8'h28);
        hold <= 8'h0A;
        wr_reg(ADDR_SEQ_CTRL, 8'h01);
        wr_reg(ADDR_SEQ_CTRL, 8'h05);
        rd_chk(ADDR_SEQ_CTRL, 8'h1F, 8'h01);
        wait_done;
        wr_reg(ADDR_BUFFER, 8'h5A);
        rd_chk(ADDR_BUFFER, 8'hFF, 8'h5A);
        wr_reg(ADDR_BUFFER, 8'hC3);
        rd_chk(ADDR_BUFFER, 8'hFF, 8'h5A);
        rd_chk(ADDR_CTRL_ONE, 8'h80, 8'h80);
        wr_reg(ADDR_CTRL_ONE, 8'hA8);
        rd_chk(ADDR_CTRL_ONE, 8'h80, 8'h80);
        wr_reg(ADDR_IRQ_MASK, 8'h02);
        chk({7'h00, irq}, 8'h01);
        wr_reg(ADDR_IRQ_FLAG, 8'h02);
        chk({7'h00, irq}, 8'h00);
        wr_reg(ADDR_IRQ_MASK, 8'h01);
        wr_reg(ADDR_CTRL_ONE, 8'h28);
        rd_chk(ADDR_CTRL_ONE, 8'h80, 8'h00);
        wait_done;
        chk(rx_byte, 8'h5A);
        rd_chk(ADDR_SEQ_CTRL, 8'h40, 8'h00);
        hold <= 8'h00;
        wr_reg(ADDR_BUFFER, 8'h81);
        wait_done;
        chk(rx_byte, 8'h81);
        wr_reg(ADDR_SEQ_CTRL, 8'h08);
        wait_done;
        rd_chk(ADDR_STATUS, 8'h19, 8'h09);
        rd_chk(ADDR_BUFFER, 8'hFF, 8'hFF);
        wr_reg(ADDR_SEQ_CTRL, 8'h10);
        wait_done;
        wr_reg(ADDR_SEQ_CTRL, 8'h02);
        wait_done;
        wr_reg(ADDR_SEQ_CTRL, 8'h04);
        wait_done;
        rd_chk(ADDR_STATUS, 8'h19, 8'h10);
        chk({4'h0, scl_drv, sda_drv, scl_oe, sda_oe}, 8'h00);
        wrap_up;
    end
    initial begin
        repeat (40000) @(posedge clock);
        n_errors++;
        $display("Error at %0t: run did not finish", $time);
        wrap_up;
    end
endmodule // testbench
bind icm_master icm_monitor u_icm_monitor (.clock(clock),
    .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .scl_in(scl_in), .scl_oe(scl_oe));
